// file: common/amd_map.vh
// constants for the operand addressing-mode decoder
// Functional notes
// - seventeen operand addressing modes in seven families, most short and long
// - long variants reach the full 64 Kbyte space using more bytes
// - short direct and short indirect variants reach only page zero, 0000h to 00FFh
// - read-modify-write instructions decode only with short addressing
// - inherent instructions are one byte, no operand bytes fetched
// - immediate instructions are two bytes, literal in second byte
// - short direct address is one byte after opcode, 00 to FF
// - no-offset indexed uses index itself; Y adds one prebyte
// - relative target is next-instruction PC plus signed byte offset
// - short indexed adds unsigned byte offset to index, up to 1FE
// - short indirect reads a byte pointer from page zero
// - indirect indexed adds index to pointer fetched from memory
// - prebyte 90 swaps X index register for Y
`ifndef AMD_MAP_VH
`define AMD_MAP_VH
`define AMD_PRE_Y 8'h90
`define AMD_PRE_IX 8'h92
`define AMD_PRE_IY 8'h91
`define AMD_M_INH 5'h00
`define AMD_M_IMM 5'h01
`define AMD_M_SDIR 5'h02
`define AMD_M_LDIR 5'h03
`define AMD_M_NIDX 5'h04
`define AMD_M_SIDX 5'h05
`define AMD_M_LIDX 5'h06
`define AMD_M_SIND 5'h07
`define AMD_M_LIND 5'h08
`define AMD_M_SIIX 5'h09
`define AMD_M_LIIX 5'h0A
`define AMD_M_RELD 5'h0B
`define AMD_M_RELI 5'h0C
`define AMD_M_BITD 5'h0D
`define AMD_M_BITI 5'h0E
`define AMD_M_BTRD 5'h0F
`define AMD_M_BTRI 5'h10
`define AMD_M_ILL 5'h1F
`endif

// file: rtl/amd_mode_table.v
// opcode to addressing-mode lookup
`timescale 1ns/1ps
`include "amd_map.vh"
module amd_mode_table (
   // opcode and prebyte kind
   input wire [7:0] opcode,
   input wire pre_ind,
   // decoded mode, rmw flag
   output reg [4:0] mode,
   output reg rmw
);
   wire [3:0] hi = opcode[7:4];
   wire [3:0] lo = opcode[3:0];
   always @* begin
      mode = `AMD_M_INH;
      rmw = 1'b0;
      case (hi)
         4'h0: begin
            mode = pre_ind ? `AMD_M_BTRI : `AMD_M_BTRD;
         end
         4'h1: begin
            mode = pre_ind ? `AMD_M_BITI : `AMD_M_BITD;
         end
         4'h2: begin
            mode = pre_ind ? `AMD_M_RELI : `AMD_M_RELD;
         end
         4'h3: begin
            // only short forms exist for rmw
            mode = pre_ind ? `AMD_M_SIND : `AMD_M_SDIR;
            rmw = 1'b1;
         end
         4'h4, 4'h5, 4'h8, 4'h9: begin
            mode = `AMD_M_INH;
         end
         4'h6: begin
            mode = pre_ind ? `AMD_M_SIIX : `AMD_M_SIDX;
            rmw = 1'b1;
         end
         4'h7: begin
            mode = `AMD_M_NIDX;
            rmw = 1'b1;
         end
         4'hA: begin
            mode = `AMD_M_IMM;
         end
         4'hB: begin
            mode = pre_ind ? `AMD_M_SIND : `AMD_M_SDIR;
         end
         4'hC: begin
            mode = pre_ind ? `AMD_M_LIND : `AMD_M_LDIR;
         end
         4'hD: begin
            mode = pre_ind ? `AMD_M_LIIX : `AMD_M_LIDX;
         end
         4'hE: begin
            mode = pre_ind ? `AMD_M_SIIX : `AMD_M_SIDX;
         end
         4'hF: begin
            mode = `AMD_M_NIDX;
         end
         default: begin
            mode = `AMD_M_ILL;
         end
      endcase
      if (hi == 4'hA && lo == 4'hD) begin
         mode = `AMD_M_RELD;
      end
   end
endmodule // amd_mode_table

// file: rtl/amd_decoder.v
// operand addressing-mode decoder and effective address former
`timescale 1ns/1ps
`include "amd_map.vh"
module amd_decoder (
   // clock and reset
   input wire clk,
   input wire rstn,
   // fetch stream
   input wire byte_valid,
   input wire [7:0] byte_data,
   input wire [15:0] pc_next,
   output wire byte_ready,
   // index registers
   input wire [7:0] x_index,
   input wire [7:0] y_index,
   // data memory pointer read
   output reg mem_req,
   output reg [15:0] mem_addr,
   input wire mem_ack,
   input wire [7:0] mem_rdata,
   // decoded result
   output reg done,
   output reg [4:0] mode_out,
   output reg [2:0] length_out,
   output reg [15:0] ea_out,
   output reg [7:0] literal_out,
   output reg [7:0] opcode_out,
   output reg use_y,
   output reg rmw_out
);
   localparam S_OP = 3'd0;
   localparam S_B1 = 3'd1;
   localparam S_B2 = 3'd2;
   localparam S_PH = 3'd3;
   localparam S_PL = 3'd4;
   localparam S_B3 = 3'd5;
   localparam S_DONE = 3'd6;

   reg [2:0] state_reg;
   reg [2:0] len_reg;
   reg pre_y_reg, pre_ind_reg, pre_iy_reg;
   reg [7:0] op_reg, b1_reg, b2_reg, ph_reg;
   wire [4:0] tmode;
   wire trmw;

   amd_mode_table u_table (
      .opcode(byte_data),
      .pre_ind(pre_ind_reg),
      .mode(tmode),
      .rmw(trmw)
   );

   // operand bytes needed after the opcode
   function [1:0] opnd_bytes;
      input [4:0] m;
      begin
         case (m)
            `AMD_M_INH, `AMD_M_NIDX: opnd_bytes = 2'd0;
            `AMD_M_LDIR, `AMD_M_LIDX, `AMD_M_BTRD: opnd_bytes = 2'd2;
            `AMD_M_BTRI: opnd_bytes = 2'd2;
            default: opnd_bytes = 2'd1;
         endcase
      end
   endfunction

   function is_ptr;
      input [4:0] m;
      begin
         is_ptr = (m == `AMD_M_SIND) || (m == `AMD_M_LIND) ||
            (m == `AMD_M_SIIX) || (m == `AMD_M_LIIX) ||
            (m == `AMD_M_RELI) || (m == `AMD_M_BITI) || (m == `AMD_M_BTRI);
      end
   endfunction

   wire [7:0] idx = (pre_y_reg | pre_iy_reg) ? y_index : x_index;
   wire is_pre = (byte_data == `AMD_PRE_Y) || (byte_data == `AMD_PRE_IX) ||
      (byte_data == `AMD_PRE_IY);
   wire [15:0] rel_off = {{8{b1_reg[7]}}, b1_reg};
   wire [15:0] rel_ptr = {{8{mem_rdata[7]}}, mem_rdata};

   assign byte_ready = (state_reg == S_OP) || (state_reg == S_B1) ||
      (state_reg == S_B2) || (state_reg == S_B3);

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= S_OP;
         len_reg <= 3'd0;
         pre_y_reg <= 1'b0;
         pre_ind_reg <= 1'b0;
         pre_iy_reg <= 1'b0;
         op_reg <= 8'h00;
         b1_reg <= 8'h00;
         b2_reg <= 8'h00;
         ph_reg <= 8'h00;
         mem_req <= 1'b0;
         mem_addr <= 16'h0000;
         done <= 1'b0;
         mode_out <= `AMD_M_INH;
         length_out <= 3'd0;
         ea_out <= 16'h0000;
         literal_out <= 8'h00;
         opcode_out <= 8'h00;
         use_y <= 1'b0;
         rmw_out <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state_reg)
            S_OP: begin
               if (byte_valid && is_pre) begin
                  pre_y_reg <= (byte_data == `AMD_PRE_Y);
                  pre_ind_reg <= (byte_data != `AMD_PRE_Y);
                  pre_iy_reg <= (byte_data == `AMD_PRE_IY);
                  len_reg <= 3'd1;
               end else if (byte_valid) begin
                  op_reg <= byte_data;
                  opcode_out <= byte_data;
                  mode_out <= tmode;
                  rmw_out <= trmw;
                  use_y <= pre_y_reg | pre_iy_reg;
                  // prebyte, opcode and operands
                  len_reg <= len_reg + 3'd1 + {1'b0, opnd_bytes(tmode)};
                  if (opnd_bytes(tmode) == 2'd0) begin
                     // ea_out and length_out wait for the DONE state and change with the
                     // done pulse; mode_out and opcode_out are set a cycle earlier
                     state_reg <= S_DONE;
                  end else begin
                     state_reg <= S_B1;
                  end
               end
            end
            S_B1: begin
               if (byte_valid) begin
                  b1_reg <= byte_data;
                  if (opnd_bytes(mode_out) == 2'd2) begin
                     state_reg <= S_B2;
                  end else if (is_ptr(mode_out)) begin
                     // first pointer address is always page zero; a long pointer's second byte is read from the next address
                     mem_addr <= {8'h00, byte_data};
                     mem_req <= 1'b1;
                     state_reg <= (mode_out == `AMD_M_LIND ||
                        mode_out == `AMD_M_LIIX) ? S_PH : S_PL;
                  end else begin
                     state_reg <= S_DONE;
                  end
               end
            end
            S_B2: begin
               if (byte_valid) begin
                  b2_reg <= byte_data;
                  if (mode_out == `AMD_M_BTRI) begin
                     mem_addr <= {8'h00, b1_reg};
                     mem_req <= 1'b1;
                     state_reg <= S_PL;
                  end else begin
                     state_reg <= S_DONE;
                  end
               end
            end
            S_PH: begin
               if (mem_ack) begin
                  ph_reg <= mem_rdata;
                  mem_addr <= mem_addr + 16'h0001;
                  state_reg <= S_PL;
               end
            end
            S_PL: begin
               if (mem_ack) begin
                  mem_req <= 1'b0;
                  length_out <= len_reg;
                  state_reg <= S_OP;
                  done <= 1'b1;
                  pre_y_reg <= 1'b0;
                  pre_ind_reg <= 1'b0;
                  pre_iy_reg <= 1'b0;
                  len_reg <= 3'd0;
                  case (mode_out)
                     `AMD_M_LIND: ea_out <= {ph_reg, mem_rdata};
                     `AMD_M_SIIX: ea_out <= {8'h00, mem_rdata} +
                        {8'h00, idx};
                     `AMD_M_LIIX: ea_out <= {ph_reg, mem_rdata} +
                        {8'h00, idx};
                     `AMD_M_RELI: ea_out <= pc_next + rel_ptr;
                     `AMD_M_BTRI: ea_out <= {8'h00, mem_rdata};
                     default: ea_out <= {8'h00, mem_rdata};
                  endcase
                  literal_out <= (mode_out == `AMD_M_BTRI) ? b2_reg :
                     8'h00;
               end
            end
            S_DONE: begin
               done <= 1'b1;
               length_out <= len_reg;
               state_reg <= S_OP;
               pre_y_reg <= 1'b0;
               pre_ind_reg <= 1'b0;
               pre_iy_reg <= 1'b0;
               len_reg <= 3'd0;
               literal_out <= b1_reg;
               case (mode_out)
                  `AMD_M_SDIR, `AMD_M_BITD: ea_out <= {8'h00, b1_reg};
                  // long full 64 Kbyte reach
                  `AMD_M_LDIR: ea_out <= {b1_reg, b2_reg};
                  `AMD_M_SIDX: ea_out <= {8'h00, b1_reg} +
                     {8'h00, idx};
                  `AMD_M_LIDX: ea_out <= {b1_reg, b2_reg} + {8'h00, idx};
                  `AMD_M_RELD: ea_out <= pc_next + rel_off;
                  `AMD_M_BTRD: begin
                     ea_out <= {8'h00, b1_reg};
                     literal_out <= b2_reg;
                  end
                  `AMD_M_NIDX: ea_out <= {8'h00, idx};
                  default: ea_out <= 16'h0000;
               endcase
            end
            default: begin
               state_reg <= S_OP;
            end
         endcase
      end
   end
endmodule // amd_decoder

// file: dv/amd_decoder_props.sv
// checker for the addressing-mode decoder ports
`timescale 1ns/1ps
`include "amd_map.vh"
module amd_decoder_props (
   // clock and reset
   input wire clk,
   input wire rstn,
   // fetch and pointer read
   input wire byte_ready,
   input wire mem_req,
   input wire [15:0] mem_addr,
   input wire mem_ack,
   // results
   input wire done,
   input wire [4:0] mode_out,
   input wire [2:0] length_out,
   input wire [15:0] ea_out,
   input wire use_y,
   input wire rmw_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_done_single: assert property (done |=> !done)
      else $error("done pulse longer than one cycle");
   a_done_gap: assert property (done |-> !$past(byte_ready))
      else $error("done without a closing state");
   a_ptr_page: assert property (
      $rose(mem_req) |-> mem_addr[15:8] == 8'h00)
      else $error("pointer address outside page zero");
   a_ptr_steady: assert property (
      mem_req && !mem_ack |=> $stable(mem_addr))
      else $error("pointer address moved while waiting");
   a_ptr_done: assert property ($fell(mem_req) |-> ##[0:1] done)
      else $error("no result after pointer read");
   a_inh_len: assert property (
      done && mode_out == `AMD_M_INH && !use_y |-> length_out == 3'h1)
      else $error("inherent length wrong");
   a_imm_len: assert property (
      done && mode_out == `AMD_M_IMM |-> length_out == 3'h2 + use_y)
      else $error("immediate length wrong");
   a_sdir_page: assert property (done && mode_out == `AMD_M_SDIR |->
      ea_out[15:8] == 8'h00 && length_out == 3'h2 + use_y)
      else $error("short direct address or length wrong");
   a_nidx_len: assert property (done && mode_out == `AMD_M_NIDX |->
      ea_out[15:8] == 8'h00 && length_out == 3'h1 + use_y)
      else $error("no-offset indexed wrong");
   a_sidx_range: assert property (done && (mode_out == `AMD_M_SIDX ||
      mode_out == `AMD_M_SIIX) |-> ea_out <= 16'h01FE)
      else $error("short indexed address out of range");
   a_rmw_short: assert property (done && rmw_out |->
      mode_out != `AMD_M_LDIR && mode_out != `AMD_M_LIDX)
      else $error("read-modify-write with long mode");
   a_long_len: assert property (
      done && mode_out == `AMD_M_LDIR |-> length_out == 3'h3 + use_y)
      else $error("long direct length wrong");
   a_result_hold: assert property (
      !done |-> $stable(ea_out) && $stable(length_out))
      else $error("result changed between completions");

   c_ind: cover property (done && mode_out == `AMD_M_SIND);
   c_y: cover property (done && use_y);
   c_ack: cover property (mem_req && mem_ack);
endmodule // amd_decoder_props

bind amd_decoder amd_decoder_props i_props (.clk, .rstn, .byte_ready,
   .mem_req, .mem_addr, .mem_ack, .done, .mode_out, .length_out, .ea_out,
   .use_y, .rmw_out);

// file: dv/test_cpu_addressing_mode_decoder.sv
// self-checking bench for the addressing-mode decoder
`timescale 1ns/1ps
`include "amd_map.vh"
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin \
   failures++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module test_cpu_addressing_mode_decoder;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic byte_valid = 1'b0;
   logic [7:0] byte_data = 8'h00;
   logic [15:0] pc_next = 16'h1000;
   logic [7:0] x_index = 8'hFF;
   logic [7:0] y_index = 8'h80;
   logic mem_ack = 1'b0;
   logic [7:0] mem_rdata = 8'h00;
   wire byte_ready, mem_req, done, use_y, rmw_out;
   wire [15:0] mem_addr, ea_out;
   wire [4:0] mode_out;
   wire [2:0] length_out;
   wire [7:0] literal_out, opcode_out;
   integer failures = 0;
   integer tests_run = 0;
   logic [15:0] seen_addr = 16'h0000;

   always #50 clk = ~clk;

   amd_decoder i_dut (.clk, .rstn, .byte_valid, .byte_data, .pc_next,
      .byte_ready, .x_index, .y_index, .mem_req, .mem_addr, .mem_ack,
      .mem_rdata, .done, .mode_out, .length_out, .ea_out, .literal_out,
      .opcode_out, .use_y, .rmw_out);

   task put(input [7:0] b);
      begin
         while (byte_ready !== 1'b1) @(negedge clk);
         byte_valid = 1'b1;
         byte_data = b;
         @(negedge clk);
      end
   endtask

   // valid stays up between bytes so it is never toggled twice per step
   task go(input [31:0] seq, input integer nb, input [7:0] rd,
         input [4:0] em, input [2:0] el, input [15:0] ea);
      integer i;
      logic [7:0] eop;
      begin
         eop = (seq[31:24] == `AMD_PRE_Y || seq[31:24] == `AMD_PRE_IX ||
            seq[31:24] == `AMD_PRE_IY) ? seq[23:16] : seq[31:24];
         for (i = 0; i < nb; i++) put(seq[31 - 8 * i -: 8]);
         byte_valid = 1'b0;
         for (i = 0; i < 20 && done !== 1'b1; i++) begin
            mem_ack = mem_req === 1'b1 && mem_ack === 1'b0;
            if (mem_ack) seen_addr = mem_addr;
            // released data shows the inverse, not a stale match
            mem_rdata = mem_ack ? rd : ~rd;
            @(negedge clk);
         end
         mem_ack = 1'b0;
         `CHK("done", 1'b1, done)
         `CHK("mode", em, mode_out)
         `CHK("length", el, length_out)
         `CHK("opcode", eop, opcode_out)
         if (em != `AMD_M_INH && em != `AMD_M_IMM) `CHK("ea", ea, ea_out)
      end
   endtask

   task t_short;
      begin
         `CHK("ready", 1'b1, byte_ready)
         go({8'h40, 24'h0}, 1, 8'h00, `AMD_M_INH, 3'h1, 16'h0);
         go(32'hA6550000, 2, 8'h00, `AMD_M_IMM, 3'h2, 16'h0);
         `CHK("literal", 8'h55, literal_out)
         go(32'hB6FF0000, 2, 8'h00, `AMD_M_SDIR, 3'h2, 16'h00FF);
         go(32'h3A200000, 2, 8'h00, `AMD_M_SDIR, 3'h2, 16'h0020);
         `CHK("rmw", 1'b1, rmw_out)
         $display("short mode test done");
      end
   endtask

   task t_long;
      begin
         go(32'hC6123400, 3, 8'h00, `AMD_M_LDIR, 3'h3, 16'h1234);
         `CHK("rmw", 1'b0, rmw_out)
         go(32'hD6123400, 3, 8'h00, `AMD_M_LIDX, 3'h3, 16'h1333);
         $display("long mode test done");
      end
   endtask

   task t_index;
      begin
         go(32'hE6FF0000, 2, 8'h00, `AMD_M_SIDX, 3'h2, 16'h01FE);
         go(32'hF6000000, 1, 8'h00, `AMD_M_NIDX, 3'h1, 16'h00FF);
         `CHK("use_y", 1'b0, use_y)
         go(32'h90F60000, 2, 8'h00, `AMD_M_NIDX, 3'h2, 16'h0080);
         `CHK("use_y", 1'b1, use_y)
         go(32'h90E61000, 3, 8'h00, `AMD_M_SIDX, 3'h3, 16'h0090);
         $display("indexed test done");
      end
   endtask

   task t_rel;
      begin
         go(32'h27800000, 2, 8'h00, `AMD_M_RELD, 3'h2, 16'h0F80);
         go(32'h277F0000, 2, 8'h00, `AMD_M_RELD, 3'h2, 16'h107F);
         $display("relative test done");
      end
   endtask

   task t_ind;
      begin
         go(32'h92B61000, 3, 8'hC5, `AMD_M_SIND, 3'h3, 16'h00C5);
         `CHK("ptr_addr", 16'h0010, seen_addr)
         x_index = 8'h0F;
         go(32'h92E62000, 3, 8'hF0, `AMD_M_SIIX, 3'h3, 16'h00FF);
         `CHK("ptr_addr", 16'h0020, seen_addr)
         $display("indirect test done");
      end
   endtask

   // long pointers come high byte first, so both bytes read the same here
   task t_more;
      begin
         go(32'h92C61000, 3, 8'h12, `AMD_M_LIND, 3'h3, 16'h1212);
         `CHK("ptr_addr", 16'h0011, seen_addr)
         go(32'h91D63000, 3, 8'h20, `AMD_M_LIIX, 3'h3, 16'h20A0);
         `CHK("use_y", 1'b1, use_y)
         go(32'h92274000, 3, 8'hF0, `AMD_M_RELI, 3'h3, 16'h0FF0);
         go(32'h12330000, 2, 8'h00, `AMD_M_BITD, 3'h2, 16'h0033);
         go(32'h92125000, 3, 8'h44, `AMD_M_BITI, 3'h3, 16'h0044);
         go(32'h03340900, 3, 8'h00, `AMD_M_BTRD, 3'h3, 16'h0034);
         `CHK("literal", 8'h09, literal_out)
         go(32'h92056007, 4, 8'h66, `AMD_M_BTRI, 3'h4, 16'h0066);
         `CHK("literal", 8'h07, literal_out)
         `CHK("ptr_addr", 16'h0060, seen_addr)
         $display("pointer and bit test done");
      end
   endtask

   task finish_test;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, failures);
         if (failures == 0 && tests_run > 0) begin
            $display("verification passed");
         end else begin
            $display("verification failed");
         end
         $finish;
      end
   endtask

   initial begin
      repeat (12) @(negedge clk);
      rstn = 1'b1;
      t_short();
      t_long();
      t_index();
      t_rel();
      t_ind();
      t_more();
      finish_test();
   end

   // the tests need about 90 cycles; over fifty times that means a hang
   initial begin
      #(100 * 5000);
      failures++;
      $display("watchdog expired");
      finish_test();
   end
endmodule // test_cpu_addressing_mode_decoder
